// file: isr_pkg.sv
// constants, command selects and carrier types for the status reporting block
// assumes one instrument clock; used by isr_status_reporting and its testbench
package isr_pkg;

    // register widths
    localparam int COND_W = 16;
    localparam int STD_W = 8;
    localparam int DATA_W = 16;

    // operation group bit positions
    localparam int OPER_CAL_DONE_BIT = 0;
    localparam int OPER_TRANSIENT_DONE_BIT = 3;
    localparam int OPER_MEASUREMENT_DONE_BIT = 4;

    // fault (questionable) group bit positions
    localparam int FAULT_OUTPUT_VOLTAGE_BIT = 0;
    localparam int FAULT_OVERCURRENT_BIT = 1;
    localparam int FAULT_OVERTEMPERATURE_BIT = 3;
    localparam int FAULT_REMOTE_SHUTDOWN_BIT = 9;
    localparam int FAULT_RMS_LIMIT_BIT = 12;

    // standard event bit positions
    localparam int STD_OP_COMPLETE_BIT = 0;
    localparam int STD_QUERY_ERR_BIT = 2;
    localparam int STD_DEVICE_ERR_BIT = 3;
    localparam int STD_EXEC_ERR_BIT = 4;
    localparam int STD_COMMAND_ERR_BIT = 5;
    localparam int STD_POWER_ON_BIT = 7;
    // pulse bits that may latch; power-on comes from the boot cycle only,
    // so a stray parser pulse cannot fake a power loss
    localparam logic [7:0] STD_DEFINED = 8'h3d;

    // status byte bit positions
    localparam int STB_FAULT_SUM_BIT = 3;
    localparam int STB_MSG_AVAIL_BIT = 4;
    localparam int STB_STD_SUM_BIT = 5;
    localparam int STB_SERVICE_BIT = 6;
    localparam int STB_OPER_SUM_BIT = 7;

    // reset values
    localparam logic [15:0] COND_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    // register selects of the command port
    typedef enum logic [3:0] {
        SEL_OPER_COND = 4'h0,
        SEL_OPER_EVENT = 4'h1,
        SEL_OPER_MASK = 4'h2,
        SEL_FAULT_COND = 4'h3,
        SEL_FAULT_EVENT = 4'h4,
        SEL_FAULT_MASK = 4'h5,
        SEL_STD_EVENT = 4'h6,
        SEL_STD_MASK = 4'h7,
        SEL_STATUS_BYTE = 4'h8,
        SEL_SERIAL_POLL = 4'h9,
        SEL_SERVICE_MASK = 4'ha,
        SEL_POWER_ON_CLEAR = 4'hb
    } isr_sel_type;

    // one command from the interface parser
    typedef struct packed {
        isr_sel_type sel;
        logic write;
        logic [15:0] wdata;
    } isr_cmd_type;

endpackage

// file: isr_status_reporting.sv
// status reporting core: operation, fault and standard event groups feeding the status byte
// assumes a command parser drives one register command per cycle, synchronous to CLK,
// and that power-up of the instrument is signalled by RESET
`timescale 1ns/10ps

module isr_status_reporting (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // monitored circuits
    input wire logic [15:0] OPER_COND,
    input wire logic [15:0] FAULT_COND,
    input wire logic [7:0] STD_EVENT_PULSE,
    input wire logic OUTQ_NOT_EMPTY,
    // register command port
    input wire logic CMD_VALID,
    input wire isr_pkg::isr_cmd_type CMD,
    output logic RSP_VALID,
    output logic [15:0] RSP_DATA,
    // non-volatile power-on clear setting
    input wire logic PSC_NV_VALUE,
    output logic PSC_NV_WRITE,
    output logic PSC_NV_DATA,
    // service request and status byte view
    output logic SRQ,
    output logic [7:0] STATUS_BYTE
);

    // event latches and masks
    logic [15:0] oper_event_q, oper_event_d;
    logic [15:0] oper_mask_q, oper_mask_d;
    logic [15:0] fault_event_q, fault_event_d;
    logic [15:0] fault_mask_q, fault_mask_d;
    logic [7:0] std_event_q, std_event_d;
    logic [7:0] std_mask_q, std_mask_d;
    logic [7:0] srv_mask_q, srv_mask_d;
    // power-on clear setting and first-cycle marker
    logic psc_q, psc_d;
    logic boot_q, boot_d;
    // service request flag and last master summary
    logic rqs_q, rqs_d;
    logic mss_prev_q, mss_prev_d;
    // response and store outputs
    logic rsp_valid_d;
    logic [15:0] rsp_data_d;
    logic nv_write_d, nv_data_d;
    // combinational summaries
    logic oper_sum, fault_sum, std_sum, mss;
    logic [7:0] stb_base;
    logic rd, wr;

    // command decode
    assign rd = CMD_VALID & ~CMD.write;
    assign wr = CMD_VALID & CMD.write;

    // group summaries and status byte without bit 6
    always_comb begin
        oper_sum = |(oper_event_q & oper_mask_q);
        fault_sum = |(fault_event_q & fault_mask_q);
        std_sum = |(std_event_q & std_mask_q);
        stb_base = isr_pkg::BYTE_RESET;
        stb_base[isr_pkg::STB_OPER_SUM_BIT] = oper_sum;
        stb_base[isr_pkg::STB_FAULT_SUM_BIT] = fault_sum;
        stb_base[isr_pkg::STB_MSG_AVAIL_BIT] = OUTQ_NOT_EMPTY;
        stb_base[isr_pkg::STB_STD_SUM_BIT] = std_sum;
        // real time, never latched: it falls as soon as the causes go
        mss = |(stb_base & srv_mask_q);
    end

    // next values of event latches and masks
    always_comb begin
        // latches take any asserted condition, std only its defined pulses; a set in the read cycle survives the clear
        oper_event_d = oper_event_q;
        if (rd && CMD.sel == isr_pkg::SEL_OPER_EVENT) begin
            oper_event_d = isr_pkg::COND_RESET;
        end
        oper_event_d = oper_event_d | OPER_COND;
        fault_event_d = fault_event_q;
        if (rd && CMD.sel == isr_pkg::SEL_FAULT_EVENT) begin
            fault_event_d = isr_pkg::COND_RESET;
        end
        fault_event_d = fault_event_d | FAULT_COND;
        std_event_d = std_event_q;
        if (rd && CMD.sel == isr_pkg::SEL_STD_EVENT) begin
            std_event_d = isr_pkg::BYTE_RESET;
        end
        std_event_d = std_event_d | (STD_EVENT_PULSE & isr_pkg::STD_DEFINED);
        if (boot_q) begin
            std_event_d[isr_pkg::STD_POWER_ON_BIT] = 1'b1;
        end
        // masks: read/write storage; std and service masks also armed in the boot cycle when power-on clear is off
        oper_mask_d = oper_mask_q;
        fault_mask_d = fault_mask_q;
        std_mask_d = std_mask_q;
        srv_mask_d = srv_mask_q;
        psc_d = psc_q;
        nv_write_d = 1'b0;
        nv_data_d = PSC_NV_DATA;
        boot_d = 1'b0;
        if (boot_q) begin
            // power-on clear off: arm power-on event to request service
            psc_d = PSC_NV_VALUE;
            if (!PSC_NV_VALUE) begin
                std_mask_d[isr_pkg::STD_POWER_ON_BIT] = 1'b1;
                srv_mask_d[isr_pkg::STB_STD_SUM_BIT] = 1'b1;
            end
        end else if (wr) begin
            case (CMD.sel)
                isr_pkg::SEL_OPER_MASK: oper_mask_d = CMD.wdata;
                isr_pkg::SEL_FAULT_MASK: fault_mask_d = CMD.wdata;
                isr_pkg::SEL_STD_MASK: std_mask_d = CMD.wdata[7:0];
                isr_pkg::SEL_SERVICE_MASK: srv_mask_d = CMD.wdata[7:0];
                isr_pkg::SEL_POWER_ON_CLEAR: begin
                    // new setting goes straight to the non-volatile store
                    psc_d = CMD.wdata[0];
                    nv_write_d = 1'b1;
                    nv_data_d = CMD.wdata[0];
                end
                // condition, event and status byte writes are dropped
                default: psc_d = psc_q;
            endcase
        end
    end

    // register event latches and masks
    always_ff @(posedge CLK) begin
        if (RESET) begin
            // latches and masks cleared at power-up; psc_q and boot_q set
            oper_event_q <= isr_pkg::COND_RESET;
            fault_event_q <= isr_pkg::COND_RESET;
            std_event_q <= isr_pkg::BYTE_RESET;
            oper_mask_q <= isr_pkg::COND_RESET;
            fault_mask_q <= isr_pkg::COND_RESET;
            std_mask_q <= isr_pkg::BYTE_RESET;
            srv_mask_q <= isr_pkg::BYTE_RESET;
            psc_q <= 1'b1;
            boot_q <= 1'b1;
            PSC_NV_WRITE <= 1'b0;
            PSC_NV_DATA <= 1'b0;
        end else begin
            oper_event_q <= oper_event_d;
            fault_event_q <= fault_event_d;
            std_event_q <= std_event_d;
            oper_mask_q <= oper_mask_d;
            fault_mask_q <= fault_mask_d;
            std_mask_q <= std_mask_d;
            srv_mask_q <= srv_mask_d;
            psc_q <= psc_d;
            boot_q <= boot_d;
            PSC_NV_WRITE <= nv_write_d;
            PSC_NV_DATA <= nv_data_d;
        end
    end

    // next values of service request and read response
    always_comb begin
        mss_prev_d = mss;
        rqs_d = rqs_q;
        if (rd && CMD.sel == isr_pkg::SEL_SERIAL_POLL) begin
            rqs_d = 1'b0;
        end
        // a new reason for service wins over a poll in the same cycle
        if (mss && !mss_prev_q) begin
            rqs_d = 1'b1;
        end
        rsp_valid_d = rd;
        rsp_data_d = isr_pkg::DATA_RESET;
        case (CMD.sel)
            isr_pkg::SEL_OPER_COND: rsp_data_d = OPER_COND;
            isr_pkg::SEL_OPER_EVENT: rsp_data_d = oper_event_q;
            isr_pkg::SEL_OPER_MASK: rsp_data_d = oper_mask_q;
            isr_pkg::SEL_FAULT_COND: rsp_data_d = FAULT_COND;
            isr_pkg::SEL_FAULT_EVENT: rsp_data_d = fault_event_q;
            isr_pkg::SEL_FAULT_MASK: rsp_data_d = fault_mask_q;
            isr_pkg::SEL_STD_EVENT: rsp_data_d = {8'h00, std_event_q};
            isr_pkg::SEL_STD_MASK: rsp_data_d = {8'h00, std_mask_q};
            isr_pkg::SEL_STATUS_BYTE: begin
                rsp_data_d = {8'h00, stb_base};
                rsp_data_d[isr_pkg::STB_SERVICE_BIT] = mss;
            end
            isr_pkg::SEL_SERIAL_POLL: begin
                rsp_data_d = {8'h00, stb_base};
                rsp_data_d[isr_pkg::STB_SERVICE_BIT] = rqs_q;
            end
            isr_pkg::SEL_SERVICE_MASK: rsp_data_d = {8'h00, srv_mask_q};
            isr_pkg::SEL_POWER_ON_CLEAR: rsp_data_d = {15'h0000, psc_q};
            default: rsp_data_d = isr_pkg::DATA_RESET;
        endcase
        if (!rd) begin
            // data holds between reads so a slow parser can sample late
            rsp_data_d = RSP_DATA;
        end
    end

    // register service request and response
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rqs_q <= 1'b0;
            mss_prev_q <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_DATA <= isr_pkg::DATA_RESET;
        end else begin
            rqs_q <= rqs_d;
            mss_prev_q <= mss_prev_d;
            RSP_VALID <= rsp_valid_d;
            RSP_DATA <= rsp_data_d;
        end
    end

    // request line follows the latched flag
    assign SRQ = rqs_q;
    always_comb begin
        STATUS_BYTE = stb_base;
        STATUS_BYTE[isr_pkg::STB_SERVICE_BIT] = rqs_q;
    end

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_reset_clears_masks: assert property (
        $fell(RESET) |-> (oper_mask_q == 16'h0000 && fault_mask_q == 16'h0000))
        else $error("masks not cleared at power up");
    a_psc_arms_pon: assert property (
        (boot_q && !PSC_NV_VALUE) |=> (std_mask_q[7] && srv_mask_q[5]))
        else $error("power-on clear off did not arm power-on request");
    a_cond_read_live: assert property (
        (rd && CMD.sel == isr_pkg::SEL_FAULT_COND) |=> RSP_DATA == $past(FAULT_COND))
        else $error("condition read not live");
    a_event_latches: assert property (
        (OPER_COND != 16'h0000) |=> ((oper_event_q & $past(OPER_COND)) == $past(OPER_COND)))
        else $error("condition not latched into event");
    a_event_read_clear: assert property (
        (rd && CMD.sel == isr_pkg::SEL_FAULT_EVENT && FAULT_COND == 16'h0000)
        |=> fault_event_q == 16'h0000)
        else $error("event read did not clear");
    a_mask_write_stores: assert property (
        (wr && !boot_q && CMD.sel == isr_pkg::SEL_OPER_MASK) |=> oper_mask_q == $past(CMD.wdata))
        else $error("mask write lost");
    a_oper_summary_bit: assert property (
        STATUS_BYTE[7] == |(oper_event_q & oper_mask_q))
        else $error("operation summary wrong");
    a_fault_summary_bit: assert property (
        (fault_event_q & fault_mask_q) != 16'h0000 |-> STATUS_BYTE[3])
        else $error("fault summary wrong");
    a_std_read_clear: assert property (
        (rd && CMD.sel == isr_pkg::SEL_STD_EVENT && STD_EVENT_PULSE == 8'h00 && !boot_q)
        |=> std_event_q == 8'h00 ##0 !STATUS_BYTE[5])
        else $error("standard event read did not clear");
    a_pon_after_boot: assert property (
        $fell(boot_q) |-> std_event_q[7])
        else $error("power-on bit missing");
    a_rqs_on_request: assert property (
        (mss && !mss_prev_q) |=> SRQ ##1 1'b1)
        else $error("service request not raised");
    a_stb_read_keeps: assert property (
        (rd && CMD.sel == isr_pkg::SEL_STATUS_BYTE) |=> SRQ == $past(SRQ) || SRQ)
        else $error("status byte read cleared request");
    a_poll_clears_rqs: assert property (
        (rd && CMD.sel == isr_pkg::SEL_SERIAL_POLL && !(mss && !mss_prev_q))
        |=> !SRQ && RSP_DATA[6] == $past(rqs_q))
        else $error("serial poll did not clear request");
    a_mav_follows: assert property (
        STATUS_BYTE[4] == OUTQ_NOT_EMPTY)
        else $error("message available wrong");
    // undefined standard event positions must never hold a one
    a_std_pulse_defined: assert property (
        std_event_q[1] == 1'b0 && std_event_q[6] == 1'b0)
        else $error("undefined standard event bit latched");
    a_oper_cond_live: assert property (
        (rd && CMD.sel == isr_pkg::SEL_OPER_COND) |=> RSP_DATA == $past(OPER_COND))
        else $error("operation condition read not live");
    // a poll touches only the request flag, never the masks
    a_poll_keeps_masks: assert property (
        (rd && CMD.sel == isr_pkg::SEL_SERIAL_POLL)
        |=> (std_mask_q == $past(std_mask_q) && srv_mask_q == $past(srv_mask_q)))
        else $error("serial poll disturbed masks");

    c_fault_srq: cover property (fault_sum && srv_mask_q[3] ##[1:3] SRQ);
    c_poll: cover property (SRQ ##1 (rd && CMD.sel == isr_pkg::SEL_SERIAL_POLL) ##1 !SRQ);
    c_pon_request: cover property ($fell(boot_q) ##[1:4] SRQ);
    c_std_srq: cover property (std_sum && srv_mask_q[5] ##[1:3] SRQ);

endmodule

// file: isr_nv_store.sv
// far-side model of the non-volatile cell that keeps the power-on clear setting
// assumes the store pulse is synchronous to the instrument clock
`timescale 1ns/10ps

module isr_nv_store #(
    parameter logic INIT_VALUE = 1'b1 // setting held by a fresh cell
) (
    // clock
    input wire logic clk,
    // store request from the device
    input wire logic nv_write,
    input wire logic nv_data,
    // stored value, survives every reset
    output logic nv_value
);
    // no reset input on purpose: the value must outlive power cycles
    logic cell_q = INIT_VALUE;

    // store on the pulse, keep otherwise
    always @(posedge clk) begin
        if (nv_write) begin
            cell_q <= nv_data;
        end
    end
    assign nv_value = cell_q;
endmodule

// file: tb_instrument_status_reporting.sv
// self-checking bench for the status reporting core
// assumes the nv cell model beside it and a 100 MHz instrument clock
`timescale 1ns/10ps

module tb_instrument_status_reporting;
    logic clk, reset, cmd_valid, outq, rsp_valid, nv_wr, nv_dat, nv_val, srq;
    logic [15:0] oper_cond, fault_cond, rsp_data, v, acc_o, acc_f;
    logic [7:0] std_pulse, status_byte;
    logic [31:0] lfsr; // random source, fixed start
    isr_pkg::isr_cmd_type cmd;
    int mismatches, n_checks, cycles;
    int ob[3] = '{0, 3, 4}; // operation bit positions
    int fb[5] = '{0, 1, 3, 9, 12}; // fault bit positions

    isr_status_reporting u_dut (.CLK(clk), .RESET(reset), .OPER_COND(oper_cond),
        .FAULT_COND(fault_cond), .STD_EVENT_PULSE(std_pulse), .OUTQ_NOT_EMPTY(outq),
        .CMD_VALID(cmd_valid), .CMD(cmd), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
        .PSC_NV_VALUE(nv_val), .PSC_NV_WRITE(nv_wr), .PSC_NV_DATA(nv_dat),
        .SRQ(srq), .STATUS_BYTE(status_byte));
    isr_nv_store u_nv (.clk(clk), .nv_write(nv_wr), .nv_data(nv_dat), .nv_value(nv_val));

    // 10 ns clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard, far beyond the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic chk_b(input logic seen, input logic exp, input string msg);
        chk({15'h0000, seen}, {15'h0000, exp}, msg);
    endtask

    // one command; caller sits just after an edge, returns one idle cycle later
    task automatic xfer(input isr_pkg::isr_sel_type sel, input logic wr, input logic [15:0] wd);
        cmd = '{sel, wr, wd};
        cmd_valid = 1'b1;
        @(posedge clk);
        #1;
        if (!wr) chk_b(rsp_valid, 1'b1, "no response strobe");
        v = rsp_data;
        cmd_valid = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input isr_pkg::isr_sel_type sel, input logic [15:0] exp);
        xfer(sel, 1'b0, 16'h0000);
        chk(v, exp, "read data");
    endtask

    // hold reset three cycles, then let the boot edge pass
    task automatic do_reset();
        reset = 1'b1;
        repeat (3) @(posedge clk);
        #1 reset = 1'b0;
        @(posedge clk);
        #1;
    endtask

    // one event bit through mask, summary and clearing read
    task automatic grp(input isr_pkg::isr_sel_type ms, input isr_pkg::isr_sel_type es,
                       input logic f, input int b, input int sb);
        xfer(ms, 1'b1, 16'h0001 << b);
        if (f) fault_cond = 16'h0001 << b;
        else oper_cond = 16'h0001 << b;
        @(posedge clk);
        #1 oper_cond = 16'h0000;
        fault_cond = 16'h0000;
        chk_b(status_byte[sb], 1'b1, "summary not set");
        xfer(ms, 1'b1, ~(16'h0001 << b));
        chk_b(status_byte[sb], 1'b0, "summary not masked");
        xfer(ms, 1'b1, 16'hffff);
        rd(es, 16'h0001 << b);
        chk_b(status_byte[sb], 1'b0, "summary not cleared");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {cmd_valid, outq, oper_cond, fault_cond, std_pulse} = '0;
        cmd = '{isr_pkg::SEL_OPER_COND, 1'b0, 16'h0000};
        lfsr = 32'h8195;
        do_reset();
        rd(isr_pkg::SEL_STD_EVENT, 16'h0080);
        rd(isr_pkg::SEL_OPER_MASK, 16'h0000);
        rd(isr_pkg::SEL_FAULT_EVENT, 16'h0000);
        // random conditions: live reads, writes ignored, events accumulate
        acc_o = '0;
        acc_f = '0;
        for (int i = 0; i < 6; i++) begin
            lfsr = step(lfsr);
            oper_cond = lfsr[15:0];
            fault_cond = lfsr[31:16];
            acc_o |= lfsr[15:0];
            acc_f |= lfsr[31:16];
            xfer(isr_pkg::SEL_OPER_COND, 1'b1, ~lfsr[15:0]);
            rd(isr_pkg::SEL_OPER_COND, oper_cond);
            rd(isr_pkg::SEL_FAULT_COND, fault_cond);
        end
        oper_cond = 16'h0000;
        fault_cond = 16'h0000;
        xfer(isr_pkg::SEL_FAULT_EVENT, 1'b1, 16'h0000);
        rd(isr_pkg::SEL_OPER_EVENT, acc_o);
        rd(isr_pkg::SEL_OPER_EVENT, 16'h0000);
        rd(isr_pkg::SEL_FAULT_EVENT, acc_f);
        rd(isr_pkg::SEL_FAULT_EVENT, 16'h0000);
        // random mask readback
        for (int i = 0; i < 3; i++) begin
            lfsr = step(lfsr);
            xfer(isr_pkg::SEL_FAULT_MASK, 1'b1, lfsr[15:0]);
            rd(isr_pkg::SEL_FAULT_MASK, lfsr[15:0]);
            xfer(isr_pkg::SEL_STD_MASK, 1'b1, lfsr[31:16]);
            rd(isr_pkg::SEL_STD_MASK, {8'h00, lfsr[23:16]});
        end
        foreach (ob[i]) grp(isr_pkg::SEL_OPER_MASK, isr_pkg::SEL_OPER_EVENT, 1'b0, ob[i], 7);
        foreach (fb[i]) grp(isr_pkg::SEL_FAULT_MASK, isr_pkg::SEL_FAULT_EVENT, 1'b1, fb[i], 3);
        // each standard event position, undefined ones must not latch
        rd(isr_pkg::SEL_STD_EVENT, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            std_pulse = 8'h01 << i;
            @(posedge clk);
            #1 std_pulse = 8'h00;
            rd(isr_pkg::SEL_STD_EVENT, {8'h00, isr_pkg::STD_DEFINED & (8'h01 << i)});
        end
        xfer(isr_pkg::SEL_STD_MASK, 1'b1, 16'h0020);
        std_pulse = 8'h20;
        @(posedge clk);
        #1 std_pulse = 8'h00;
        chk_b(status_byte[5], 1'b1, "std summary not set");
        rd(isr_pkg::SEL_STD_EVENT, 16'h0020);
        chk_b(status_byte[5], 1'b0, "std summary not cleared");
        // message available drives a service request
        outq = 1'b1;
        xfer(isr_pkg::SEL_SERVICE_MASK, 1'b1, 16'h0010);
        chk_b(status_byte[4], 1'b1, "message bit");
        chk_b(srq, 1'b1, "no service request");
        rd(isr_pkg::SEL_STATUS_BYTE, 16'h0050);
        rd(isr_pkg::SEL_SERIAL_POLL, 16'h0050);
        chk({8'h00, status_byte}, 16'h0010, "poll left flag");
        chk_b(srq, 1'b0, "request not withdrawn");
        rd(isr_pkg::SEL_STATUS_BYTE, 16'h0050);
        outq = 1'b0;
        rd(isr_pkg::isr_sel_type'(4'hc), 16'h0000);
        // power-on clear off: kept across reset, arms the power-on request
        xfer(isr_pkg::SEL_POWER_ON_CLEAR, 1'b1, 16'h0000);
        chk_b(nv_val, 1'b0, "setting not stored");
        do_reset();
        rd(isr_pkg::SEL_STD_MASK, 16'h0080);
        rd(isr_pkg::SEL_SERVICE_MASK, 16'h0020);
        rd(isr_pkg::SEL_FAULT_MASK, 16'h0000);
        chk_b(srq, 1'b1, "no power-on request");
        rd(isr_pkg::SEL_POWER_ON_CLEAR, 16'h0000);
        end_sim();
    end
endmodule
